// [hw/dtfm_pkg.sv]
// Purpose: Shared constants and types for the drive terminal function map
// Assumes: 100 MHz system clock, APB register access with 32-bit data
// Notes: Function codes, reset values and register offsets live here; the bench repeats them as literals
package dtfm_pkg;
    // Terminal counts
    localparam int NUM_IN = 6;
    localparam int NUM_OUT = 4;

    // Register byte addresses
    localparam logic [7:0] ADDR_IN_POL = 8'h00;
    localparam logic [7:0] ADDR_OUT_POL = 8'h04;
    localparam logic [7:0] ADDR_REACT = 8'h08;
    localparam logic [7:0] ADDR_FUNC0 = 8'h0c;
    localparam logic [7:0] ADDR_FUNC5 = 8'h20;
    localparam logic [7:0] ADDR_DIR_LIMIT = 8'h24;
    localparam logic [7:0] ADDR_REF_CALC = 8'h28;
    localparam logic [7:0] ADDR_STATUS = 8'h2c;
    localparam logic [7:0] ADDR_CMD = 8'h30;

    // Values after reset
    localparam logic [7:0] IN_POL_RST = 8'h00;
    localparam logic [7:0] OUT_POL_RST = 8'h00;
    localparam logic [7:0] REACT_RST = 8'h00;
    localparam logic [1:0] DIR_LIMIT_RST = 2'h2;
    localparam logic [2:0] REF_CALC_RST = 3'h0;
    // Index 0 forward, 1 reverse, 2..5 input one..four
    localparam logic [5:0][7:0] FUNC_RST = {8'h12, 8'h11, 8'h10, 8'h0f, 8'h0b, 8'h08};

    // Input function codes
    localparam logic [7:0] FN_RESET = 8'h01;
    localparam logic [7:0] FN_COAST_N = 8'h02;
    localparam logic [7:0] FN_COAST_RST_N = 8'h03;
    localparam logic [7:0] FN_STOP_N = 8'h06;
    localparam logic [7:0] FN_START = 8'h08;
    localparam logic [7:0] FN_LATCH_START = 8'h09;
    localparam logic [7:0] FN_REVERSE = 8'h0a;
    localparam logic [7:0] FN_START_REV = 8'h0b;
    localparam logic [7:0] FN_FWD_ONLY = 8'h0c;
    localparam logic [7:0] FN_REV_ONLY = 8'h0d;
    localparam logic [7:0] FN_JOG = 8'h0e;
    localparam logic [7:0] FN_PRESET0 = 8'h0f;
    localparam logic [7:0] FN_FREEZE_REF = 8'h13;
    localparam logic [7:0] FN_FREEZE_OUT = 8'h14;
    localparam logic [7:0] FN_UP = 8'h15;
    localparam logic [7:0] FN_DOWN = 8'h16;
    localparam logic [7:0] FN_REF_SWITCH = 8'h18;
    localparam logic [7:0] FN_CATCH_UP = 8'h1c;
    localparam logic [7:0] FN_SLOW_DOWN = 8'h1d;
    localparam logic [7:0] FN_PULSE = 8'h20;
    localparam logic [7:0] FN_RAMP0 = 8'h22;
    localparam logic [7:0] FN_COAST = 8'h2a;
    localparam logic [7:0] FN_EXT_ALARM = 8'h2b;
    localparam logic [7:0] FN_STOP = 8'h2e;
    localparam logic [7:0] FN_MAX = 8'h6e;

    // External alarm reactions and related settings
    localparam logic [7:0] REACT_OFF = 8'h00;
    localparam logic [7:0] REACT_STOP_WARN = 8'h02;
    localparam logic [7:0] REACT_JOG_WARN = 8'h03;
    localparam logic [7:0] REACT_MAX_WARN = 8'h04;
    localparam logic [7:0] REACT_STOP_TRIP = 8'h05;
    localparam logic [1:0] DIR_BOTH = 2'h2;
    localparam logic [2:0] REF_CALC_SW12 = 3'h3;
    localparam logic [2:0] REF_CALC_SW123 = 3'h4;
    localparam logic [7:0] ALARM_CODE = 8'h66;
    localparam logic [2:0] RAMP_FOUR = 3'h3;

    // Timing
    localparam int CLK_KHZ = 100000;
    localparam int LATCH_START_MS = 4;
    localparam int UPDN_TAP_MS = 400;
    localparam int LATCH_START_CYC = LATCH_START_MS * CLK_KHZ;
    localparam int UPDN_TAP_CYC = UPDN_TAP_MS * CLK_KHZ;

    // Alarm reaction sequence
    typedef enum logic [1:0] {
        AL_IDLE = 2'b00,
        AL_STOP = 2'b01,
        AL_TRIP = 2'b10
    } dtfm_alarm_t;

    // Decoded commands to the motor-control core
    typedef struct packed {
        logic run;
        logic reverse;
        logic fwd_only;
        logic rev_only;
        logic stop_ramp;
        logic coast;
        logic drive_reset;
        logic jog;
        logic force_jog;
        logic force_max;
        logic [3:0] preset_idx;
        logic freeze_ref;
        logic freeze_out;
        logic up_step;
        logic down_step;
        logic up_ramp;
        logic down_ramp;
        logic ref_sel_valid;
        logic ref_src1;
        logic catch_up;
        logic slow_down;
        logic pulse_valid;
        logic pulse_level;
        logic [2:0] ramp_idx;
        logic follow_bus;
    } dtfm_cmd_t;
endpackage

// [hw/dtfm_top.sv]
// Purpose: Input terminal function decode and output terminal polarity for a motor drive
// Assumes: Terminal inputs synchronous to i_sys_clk; APB slave with zero wait states
// Notes: Input bit 0 forward, 1 reverse, 2..5 input one..four; output bits DO1, DO2, relay one, relay two
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module dtfm_top #(
    parameter int LATCH_CYC = dtfm_pkg::LATCH_START_CYC,
    parameter int UPDN_CYC = dtfm_pkg::UPDN_TAP_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [5:0] i_terminals,
    input wire logic [3:0] i_out_func_active,
    output logic [3:0] o_out_terminals,
    output dtfm_pkg::dtfm_cmd_t o_cmd,
    output logic o_warning,
    output logic o_trip,
    output logic [7:0] o_alarm_code
);
    // True when any terminal assigned code shows the wanted effective level
    function automatic logic term_match(input logic [5:0][7:0] funcs, input logic [5:0] lvl,
                                        input logic [7:0] code, input logic want);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < dtfm_pkg::NUM_IN; k++) begin
            if (funcs[k] == code && lvl[k] == want) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    logic [7:0] in_pol_r;
    logic [7:0] out_pol_r;
    logic [7:0] react_r;
    logic [5:0][7:0] func_r;
    logic [1:0] dir_lim_r;
    logic [2:0] ref_calc_r;
    logic [5:0] raw_r;
    logic [5:0] eff_r;
    logic [3:0] out_r;
    dtfm_pkg::dtfm_cmd_t cmd_r;
    dtfm_pkg::dtfm_cmd_t cmd_nxt;
    dtfm_pkg::dtfm_alarm_t al_state_r;
    dtfm_pkg::dtfm_alarm_t al_state_nxt;
    logic warn_r;
    logic trip_r;
    logic [7:0] code_r;
    logic latch_r;
    logic [31:0] latch_cnt_r;
    logic [1:0][31:0] ud_cnt_r;
    logic [1:0] ud_prev_r;
    logic reset_prev_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic ext_alarm;
    logic stop_req;
    logic coast_req;
    logic reset_lvl;
    logic reset_rise;
    logic start_lvl;
    logic latch_lvl;
    logic freeze_any;
    logic [1:0] ud_lvl;
    logic [1:0] ud_step;
    logic [1:0] ud_ramp;
    logic [31:0] rd_data;
    logic bad_addr;
    logic bad_data;
    logic wr_en;
    logic setup;

    // Terminal sampling, then polarity; XOR gives the cancellation for active-low functions
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            raw_r <= 6'h00;
            eff_r <= 6'h00;
        end else begin
            raw_r <= i_terminals;
            eff_r <= raw_r ^ in_pol_r[5:0];
        end
    end

    // Function-level decode shared by the command logic
    always_comb begin
        ext_alarm = term_match(func_r, eff_r, dtfm_pkg::FN_EXT_ALARM, 1'b1);
        stop_req = term_match(func_r, eff_r, dtfm_pkg::FN_STOP_N, 1'b0) |
                   term_match(func_r, eff_r, dtfm_pkg::FN_STOP, 1'b1);
        coast_req = term_match(func_r, eff_r, dtfm_pkg::FN_COAST_N, 1'b0) |
                    term_match(func_r, eff_r, dtfm_pkg::FN_COAST_RST_N, 1'b0) |
                    term_match(func_r, eff_r, dtfm_pkg::FN_COAST, 1'b1);
        reset_lvl = term_match(func_r, eff_r, dtfm_pkg::FN_RESET, 1'b1) |
                    term_match(func_r, eff_r, dtfm_pkg::FN_COAST_RST_N, 1'b0);
        start_lvl = term_match(func_r, eff_r, dtfm_pkg::FN_START, 1'b1) |
                    term_match(func_r, eff_r, dtfm_pkg::FN_START_REV, 1'b1);
        latch_lvl = term_match(func_r, eff_r, dtfm_pkg::FN_LATCH_START, 1'b1);
        freeze_any = term_match(func_r, eff_r, dtfm_pkg::FN_FREEZE_REF, 1'b1) |
                     term_match(func_r, eff_r, dtfm_pkg::FN_FREEZE_OUT, 1'b1);
        ud_lvl[0] = term_match(func_r, eff_r, dtfm_pkg::FN_UP, 1'b1);
        ud_lvl[1] = term_match(func_r, eff_r, dtfm_pkg::FN_DOWN, 1'b1);
        reset_rise = reset_lvl & ~reset_prev_r;
    end

    // Latched start: pulse must last LATCH_CYC cycles; a stop clears and wins
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            latch_cnt_r <= 32'h0;
            latch_r <= 1'b0;
        end else begin
            if (!latch_lvl) begin
                latch_cnt_r <= 32'h0;
            end else if (latch_cnt_r != 32'(LATCH_CYC)) begin
                latch_cnt_r <= latch_cnt_r + 32'h1;
            end
            if (stop_req) begin
                latch_r <= 1'b0;
            end else if (latch_lvl && latch_cnt_r == 32'(LATCH_CYC - 1)) begin
                latch_r <= 1'b1;
            end
        end
    end

    // Up/down tap timing: short press steps on release, long press ramps
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ud_cnt_r <= '0;
            ud_prev_r <= 2'h0;
            reset_prev_r <= 1'b0;
        end else begin
            for (int j = 0; j < 2; j++) begin
                if (!ud_lvl[j]) begin
                    ud_cnt_r[j] <= 32'h0;
                end else if (ud_cnt_r[j] != 32'(UPDN_CYC)) begin
                    ud_cnt_r[j] <= ud_cnt_r[j] + 32'h1;
                end
            end
            ud_prev_r <= ud_lvl;
            reset_prev_r <= reset_lvl;
        end
    end

    // Step and ramp qualifiers for up and down
    always_comb begin
        for (int j = 0; j < 2; j++) begin
            ud_step[j] = ud_prev_r[j] & ~ud_lvl[j] & (ud_cnt_r[j] < 32'(UPDN_CYC));
            ud_ramp[j] = ud_lvl[j] & (ud_cnt_r[j] == 32'(UPDN_CYC));
        end
    end

    // External alarm stop-and-trip sequence
    always_comb begin
        al_state_nxt = al_state_r;
        unique case (al_state_r)
            dtfm_pkg::AL_IDLE: begin
                if (ext_alarm && react_r == dtfm_pkg::REACT_STOP_TRIP) begin
                    al_state_nxt = dtfm_pkg::AL_STOP;
                end
            end
            dtfm_pkg::AL_STOP: begin
                al_state_nxt = dtfm_pkg::AL_TRIP;
            end
            dtfm_pkg::AL_TRIP: begin
                if (reset_rise && !(ext_alarm && react_r == dtfm_pkg::REACT_STOP_TRIP)) begin
                    al_state_nxt = dtfm_pkg::AL_IDLE;
                end
            end
            default: begin
                al_state_nxt = dtfm_pkg::AL_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            al_state_r <= dtfm_pkg::AL_IDLE;
        end else begin
            al_state_r <= al_state_nxt;
        end
    end

    // Command word assembly
    always_comb begin
        cmd_nxt = '0;
        if (freeze_any) begin
            cmd_nxt.run = (cmd_r.run | start_lvl | latch_r) & ~(stop_req | coast_req);
        end else begin
            cmd_nxt.run = start_lvl | latch_r;
        end
        cmd_nxt.reverse = (term_match(func_r, eff_r, dtfm_pkg::FN_REVERSE, 1'b1) &&
                           dir_lim_r == dtfm_pkg::DIR_BOTH) ||
                          term_match(func_r, eff_r, dtfm_pkg::FN_START_REV, 1'b1);
        cmd_nxt.fwd_only = term_match(func_r, eff_r, dtfm_pkg::FN_FWD_ONLY, 1'b1);
        cmd_nxt.rev_only = term_match(func_r, eff_r, dtfm_pkg::FN_REV_ONLY, 1'b1);
        cmd_nxt.stop_ramp = stop_req | (ext_alarm && react_r == dtfm_pkg::REACT_STOP_WARN) |
                            (al_state_r != dtfm_pkg::AL_IDLE);
        cmd_nxt.coast = coast_req;
        cmd_nxt.drive_reset = reset_rise;
        cmd_nxt.jog = term_match(func_r, eff_r, dtfm_pkg::FN_JOG, 1'b1);
        cmd_nxt.force_jog = ext_alarm && react_r == dtfm_pkg::REACT_JOG_WARN;
        cmd_nxt.force_max = ext_alarm && react_r == dtfm_pkg::REACT_MAX_WARN;
        for (int b = 0; b < 4; b++) begin
            cmd_nxt.preset_idx[b] = term_match(func_r, eff_r, dtfm_pkg::FN_PRESET0 + 8'(b), 1'b1);
        end
        cmd_nxt.freeze_ref = term_match(func_r, eff_r, dtfm_pkg::FN_FREEZE_REF, 1'b1);
        cmd_nxt.freeze_out = term_match(func_r, eff_r, dtfm_pkg::FN_FREEZE_OUT, 1'b1);
        cmd_nxt.up_step = ud_step[0];
        cmd_nxt.down_step = ud_step[1];
        cmd_nxt.up_ramp = ud_ramp[0];
        cmd_nxt.down_ramp = ud_ramp[1];
        cmd_nxt.ref_sel_valid = (ref_calc_r == dtfm_pkg::REF_CALC_SW12) ||
                                (ref_calc_r == dtfm_pkg::REF_CALC_SW123);
        cmd_nxt.ref_src1 = cmd_nxt.ref_sel_valid &&
                           term_match(func_r, eff_r, dtfm_pkg::FN_REF_SWITCH, 1'b1);
        cmd_nxt.catch_up = term_match(func_r, eff_r, dtfm_pkg::FN_CATCH_UP, 1'b1);
        cmd_nxt.slow_down = term_match(func_r, eff_r, dtfm_pkg::FN_SLOW_DOWN, 1'b1);
        cmd_nxt.pulse_valid = func_r[5] == dtfm_pkg::FN_PULSE;
        cmd_nxt.pulse_level = cmd_nxt.pulse_valid & eff_r[5];
        for (int b = 0; b < 3; b++) begin
            cmd_nxt.ramp_idx[b] = term_match(func_r, eff_r, dtfm_pkg::FN_RAMP0 + 8'(b), 1'b1);
        end
        if (|ud_ramp) begin
            cmd_nxt.ramp_idx = dtfm_pkg::RAMP_FOUR;
        end
        cmd_nxt.follow_bus = ~((ext_alarm && react_r != dtfm_pkg::REACT_OFF) ||
                               (al_state_r != dtfm_pkg::AL_IDLE));
    end

    // Registered command, alarm and output terminal state
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            cmd_r <= '0;
            warn_r <= 1'b0;
            trip_r <= 1'b0;
            code_r <= 8'h00;
            out_r <= 4'h0;
        end else begin
            cmd_r <= cmd_nxt;
            warn_r <= ext_alarm && (react_r == dtfm_pkg::REACT_STOP_WARN ||
                                    react_r == dtfm_pkg::REACT_JOG_WARN ||
                                    react_r == dtfm_pkg::REACT_MAX_WARN);
            trip_r <= al_state_nxt == dtfm_pkg::AL_TRIP;
            if ((al_state_nxt == dtfm_pkg::AL_TRIP) || (ext_alarm && react_r >= dtfm_pkg::REACT_STOP_WARN &&
                                                       react_r <= dtfm_pkg::REACT_MAX_WARN)) begin
                code_r <= dtfm_pkg::ALARM_CODE;
            end else begin
                code_r <= 8'h00;
            end
            out_r <= i_out_func_active ^ out_pol_r[3:0];
        end
    end

    // APB decode: setup phase computes answer, access phase commits
    always_comb begin
        setup = i_psel & ~i_penable;
        wr_en = i_psel & i_penable & pready_r & i_pwrite & ~pslverr_r;
        bad_addr = 1'b0;
        bad_data = 1'b0;
        rd_data = 32'h0;
        if (i_paddr[1:0] != 2'h0) begin
            bad_addr = 1'b1;
        end else if (i_paddr == dtfm_pkg::ADDR_IN_POL) begin
            rd_data = {24'h0, in_pol_r};
        end else if (i_paddr == dtfm_pkg::ADDR_OUT_POL) begin
            rd_data = {24'h0, out_pol_r};
        end else if (i_paddr == dtfm_pkg::ADDR_REACT) begin
            rd_data = {24'h0, react_r};
            bad_data = i_pwdata[7:0] == 8'h01 || i_pwdata[7:0] > dtfm_pkg::REACT_STOP_TRIP;
        end else if (i_paddr >= dtfm_pkg::ADDR_FUNC0 && i_paddr <= dtfm_pkg::ADDR_FUNC5) begin
            rd_data = {24'h0, func_r[3'(8'(i_paddr - dtfm_pkg::ADDR_FUNC0) >> 2)]};
            bad_data = i_pwdata[7:0] > dtfm_pkg::FN_MAX;
        end else if (i_paddr == dtfm_pkg::ADDR_DIR_LIMIT) begin
            rd_data = {30'h0, dir_lim_r};
            bad_data = i_pwdata[1:0] > dtfm_pkg::DIR_BOTH;
        end else if (i_paddr == dtfm_pkg::ADDR_REF_CALC) begin
            rd_data = {29'h0, ref_calc_r};
        end else if (i_paddr == dtfm_pkg::ADDR_STATUS) begin
            rd_data = {15'h0, al_state_r, out_r, latch_r, trip_r, warn_r, 2'h0, eff_r};
        end else if (i_paddr == dtfm_pkg::ADDR_CMD) begin
            rd_data = {{(32 - $bits(dtfm_pkg::dtfm_cmd_t)){1'b0}}, cmd_r};
        end else begin
            bad_addr = 1'b1;
        end
        if (!i_pwrite || i_paddr == dtfm_pkg::ADDR_STATUS || i_paddr == dtfm_pkg::ADDR_CMD) begin
            bad_data = 1'b0;
        end
    end

    // APB answer flops; one wait-free access phase
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup & (bad_addr | bad_data |
                                  (i_pwrite && (i_paddr == dtfm_pkg::ADDR_STATUS ||
                                                i_paddr == dtfm_pkg::ADDR_CMD)));
            prdata_r <= (setup && !i_pwrite && !bad_addr) ? rd_data : 32'h0;
        end
    end

    // Software-writable configuration
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            in_pol_r <= dtfm_pkg::IN_POL_RST;
            out_pol_r <= dtfm_pkg::OUT_POL_RST;
            react_r <= dtfm_pkg::REACT_RST;
            func_r <= dtfm_pkg::FUNC_RST;
            dir_lim_r <= dtfm_pkg::DIR_LIMIT_RST;
            ref_calc_r <= dtfm_pkg::REF_CALC_RST;
        end else if (wr_en) begin
            if (i_paddr == dtfm_pkg::ADDR_IN_POL) begin
                in_pol_r <= i_pwdata[7:0];
            end
            if (i_paddr == dtfm_pkg::ADDR_OUT_POL) begin
                out_pol_r <= i_pwdata[7:0];
            end
            if (i_paddr == dtfm_pkg::ADDR_REACT) begin
                react_r <= i_pwdata[7:0];
            end
            for (int k = 0; k < dtfm_pkg::NUM_IN; k++) begin
                if (i_paddr == dtfm_pkg::ADDR_FUNC0 + 8'(4 * k)) begin
                    func_r[k] <= i_pwdata[7:0];
                end
            end
            if (i_paddr == dtfm_pkg::ADDR_DIR_LIMIT) begin
                dir_lim_r <= i_pwdata[1:0];
            end
            if (i_paddr == dtfm_pkg::ADDR_REF_CALC) begin
                ref_calc_r <= i_pwdata[2:0];
            end
        end
    end

    // Output drive, all from flops
    always_comb begin
        o_prdata = prdata_r;
        o_pready = pready_r;
        o_pslverr = pslverr_r;
        o_out_terminals = out_r;
        o_cmd = cmd_r;
        o_warning = warn_r;
        o_trip = trip_r;
        o_alarm_code = code_r;
    end
endmodule

// [test/dtfm_properties.sv]
// Purpose: Port-level assertions for the drive terminal function map
// Assumes: One clock domain, asynchronous active-high reset
// Notes: Bound to dtfm_top below the module
`timescale 1ns/1ps
module dtfm_properties (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire dtfm_pkg::dtfm_cmd_t o_cmd,
    input wire logic o_warning,
    input wire logic o_trip,
    input wire logic [7:0] o_alarm_code
);
    // All checks share the system clock and reset
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    property p_ready_setup; i_psel && !i_penable |=> o_pready; endproperty
    a_ready_setup: assert property (p_ready_setup) else $error("no ready after setup");
    property p_ready_span; o_pready |-> (i_psel && i_penable) ##1 !o_pready; endproperty
    a_ready_span: assert property (p_ready_span) else $error("ready outside one access cycle");
    property p_rdata_idle; !o_pready |-> o_prdata == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside access");
    property p_code; o_alarm_code == ((o_warning || o_trip) ? 8'h66 : 8'h00); endproperty
    a_code: assert property (p_code) else $error("alarm code mismatch");
    property p_force_warn; (o_cmd.force_jog || o_cmd.force_max) |-> o_warning; endproperty
    a_force_warn: assert property (p_force_warn) else $error("forced speed without warning");
    property p_reset_pulse; o_cmd.drive_reset |=> !o_cmd.drive_reset; endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse too long");
    property p_trip_cmd; o_trip |-> o_cmd.stop_ramp && !o_cmd.follow_bus; endproperty
    a_trip_cmd: assert property (p_trip_cmd) else $error("trip without stop");
    property p_trip_clear; $fell(o_trip) |-> o_cmd.drive_reset || $past(o_cmd.drive_reset); endproperty
    a_trip_clear: assert property (p_trip_clear) else $error("trip cleared without reset");
endmodule
bind dtfm_top dtfm_properties i_props (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .o_prdata(o_prdata), .o_pready(o_pready), .o_cmd(o_cmd),
    .o_warning(o_warning), .o_trip(o_trip), .o_alarm_code(o_alarm_code));

// [test/dtfm_field_model.sv]
// Purpose: Field switches and output function sources facing the block
// Assumes: Levels change just after a rising edge
// Notes: Pulses are never shorter than the latched start minimum
`timescale 1ns/1ps
module dtfm_field_model #(
    parameter int HOLD_CYC = 8
) (
    input wire logic i_sys_clk,
    output logic [5:0] o_terminals,
    output logic [3:0] o_out_active
);
    // Idle contacts open, no output function active
    initial begin
        o_terminals = 6'h00;
        o_out_active = 4'h0;
    end
    // Set contact levels and output function states
    task automatic put(input logic [5:0] t, input logic [3:0] f);
        @(posedge i_sys_clk);
        o_terminals <= t;
        o_out_active <= f;
    endtask
    // Close one contact long enough to be taken as a start pulse
    task automatic pulse(input int b);
        @(posedge i_sys_clk);
        o_terminals[b] <= 1'b1;
        repeat (HOLD_CYC + 2) @(posedge i_sys_clk);
        o_terminals[b] <= 1'b0;
    endtask
endmodule

// [test/dtfm_top_tb.sv]
// Purpose: Self-checking bench for the drive terminal function map
// Assumes: 100 MHz clock, short latch and tap counts
// Notes: Registers over APB, terminals from the field model
`timescale 1ns/1ps
module dtfm_top_tb;
    logic sys_clk = 1'b0;
    logic rst, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, warning, trip;
    logic [5:0] terms;
    logic [3:0] out_act, out_terms;
    logic [7:0] code;
    dtfm_pkg::dtfm_cmd_t cmd;
    int failures = 0;
    int checks_done = 0;
    logic [7:0] rst_val [11] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h0b, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h02, 8'h00};
    // Clock and parts
    always #5 sys_clk = ~sys_clk;
    dtfm_field_model #(.HOLD_CYC(8)) i_field (.i_sys_clk(sys_clk), .o_terminals(terms), .o_out_active(out_act));
    dtfm_top #(.LATCH_CYC(8), .UPDN_CYC(16)) i_dut (.i_sys_clk(sys_clk), .i_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_terminals(terms), .i_out_func_active(out_act),
        .o_out_terminals(out_terms), .o_cmd(cmd), .o_warning(warning), .o_trip(trip), .o_alarm_code(code));
    // Compare and report
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until ready is seen at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Pipeline settling and helpers
    task automatic settle();
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    function automatic logic [7:0] fa(input int k);
        return dtfm_pkg::ADDR_FUNC0 + 8'(4 * k);
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #500000;
        failures++;
        wrap_up();
    end
    // Test sequence
    initial begin
        rst <= 1'b1;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        for (int k = 0; k < 11; k++) begin
            xfer(1'b0, 8'(4 * k), 32'h0);
            chk(rd, {24'h0, rst_val[k]});
        end
        xfer(1'b0, 8'h34, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        xfer(1'b1, fa(0), 32'h6f);
        xfer(1'b0, fa(0), 32'h0);
        chk(rd, 32'h8);
        $display("test registers done");
        xfer(1'b1, fa(0), 32'h8);
        i_field.put(6'h01, 4'h0);
        settle();
        chk(cmd.run, 1'b1);
        i_field.put(6'h00, 4'h0);
        settle();
        chk(cmd.run, 1'b0);
        xfer(1'b1, fa(0), 32'h6);
        xfer(1'b1, dtfm_pkg::ADDR_IN_POL, 32'h1);
        settle();
        chk(cmd.stop_ramp, 1'b0);
        i_field.put(6'h01, 4'h0);
        settle();
        chk(cmd.stop_ramp, 1'b1);
        xfer(1'b1, dtfm_pkg::ADDR_IN_POL, 32'h0);
        i_field.put(6'h00, 4'h0);
        $display("test start and polarity done");
        xfer(1'b1, fa(0), 32'h9);
        xfer(1'b1, fa(1), 32'h2e);
        i_field.pulse(0);
        settle();
        chk(cmd.run, 1'b1);
        i_field.pulse(1);
        settle();
        chk(cmd.run, 1'b0);
        $display("test latched start done");
        for (int v = 0; v < 16; v++) begin
            i_field.put({v[3:0], 2'b00}, 4'h0);
            settle();
            chk(cmd.preset_idx, v[3:0]);
        end
        for (int k = 2; k < 5; k++) xfer(1'b1, fa(k), 32'(32 + k));
        for (int v = 0; v < 8; v++) begin
            i_field.put({1'b0, v[2:0], 2'b00}, 4'h0);
            settle();
            chk(cmd.ramp_idx, v[2:0]);
        end
        xfer(1'b1, dtfm_pkg::ADDR_OUT_POL, 32'h5);
        for (int f = 0; f < 16; f++) begin
            i_field.put(6'h00, f[3:0]);
            settle();
            chk(out_terms, f[3:0] ^ 4'h5);
        end
        $display("test selects and outputs done");
        xfer(1'b1, fa(2), 32'h2b);
        xfer(1'b1, dtfm_pkg::ADDR_REACT, 32'h2);
        settle();
        chk(warning, 1'b0);
        i_field.put(6'h04, 4'h0);
        for (int r = 2; r < 5; r++) begin
            xfer(1'b1, dtfm_pkg::ADDR_REACT, 32'(r));
            settle();
            chk({warning, cmd.stop_ramp, cmd.force_jog, cmd.force_max, code}, {1'b1, r == 2, r == 3, r == 4, 8'h66});
        end
        xfer(1'b1, dtfm_pkg::ADDR_REACT, 32'h0);
        settle();
        chk({warning, cmd.follow_bus}, 2'b01);
        xfer(1'b1, dtfm_pkg::ADDR_REACT, 32'h5);
        settle();
        chk({trip, code}, {1'b1, 8'h66});
        i_field.put(6'h00, 4'h0);
        settle();
        chk(trip, 1'b1);
        xfer(1'b1, fa(1), 32'h1);
        i_field.pulse(1);
        settle();
        chk(trip, 1'b0);
        $display("test external alarm done");
        xfer(1'b1, fa(2), 32'h1c);
        xfer(1'b1, fa(3), 32'h1d);
        xfer(1'b1, fa(4), 32'h0a);
        xfer(1'b1, fa(5), 32'h20);
        i_field.put(6'h3c, 4'h0);
        settle();
        chk({cmd.catch_up, cmd.slow_down, cmd.reverse, cmd.pulse_valid, cmd.pulse_level}, 5'h1f);
        xfer(1'b1, fa(2), 32'h20);
        xfer(1'b1, fa(5), 32'h0c);
        xfer(1'b1, dtfm_pkg::ADDR_DIR_LIMIT, 32'h1);
        settle();
        chk({cmd.reverse, cmd.pulse_valid, cmd.fwd_only}, 3'h1);
        $display("test misc decode done");
        wrap_up();
    end
endmodule
